// ---- rtl/rsf_defs.svh ----
`ifndef RSF_DEFS_SVH
`define RSF_DEFS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define RSF_CLK_MHZ 125
`define RSF_TICK_US 1
`define RSF_TICK_CYC (`RSF_TICK_US * `RSF_CLK_MHZ)
`define RSF_DIV_W 7
`define RSF_PG_FILT_US 100
`define RSF_PG_FILT_TICKS (`RSF_PG_FILT_US / `RSF_TICK_US)
`define RSF_SYNC_PW_NS 500
`define RSF_SYNC_PW_CYC ((`RSF_SYNC_PW_NS * `RSF_CLK_MHZ + 999) / 1000)
`define RSF_DROP_EXTRA_NS 100
`define RSF_DROP_EXTRA_CYC ((`RSF_DROP_EXTRA_NS * `RSF_CLK_MHZ + 999) / 1000)
`define RSF_DROP_DIV 12
`define RSF_DROP_EVERY 3
`define RSF_EXT_FREQ_PCT 80

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define RSF_REG_CTRL 4'h0
`define RSF_REG_CCFG0 4'h1
`define RSF_REG_CCFG1 4'h2
`define RSF_REG_GCFG 4'h3
`define RSF_REG_MODE 4'h4
`define RSF_REG_ON_T 4'h5
`define RSF_REG_OFF_T 4'h6
`define RSF_REG_RETRY 4'h7
`define RSF_REG_FREQ 4'h8
`define RSF_REG_PHASE 4'h9
`define RSF_REG_STATUS 4'hA

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RSF_CC_SKIP_DECAY 0
`define RSF_CC_REQ_SHARE 2
`define RSF_CC_LATCH 3
`define RSF_CC_DISC_OFF 4
`define RSF_GC_MASTER 0
`define RSF_GC_INHIBIT 1
`define RSF_GC_REQ_EXT 4
`define RSF_ST_SYNC_DRV 10
`define RSF_CTRL_RST 2'h3
`define RSF_CCFG_RST 8'h00
`define RSF_GCFG_RST 8'h01
`define RSF_MODE_RST 2'h3
`define RSF_ON_T_RST 32'h03E8_0064
`define RSF_OFF_T_RST 32'h03E8_0064
`define RSF_RETRY_RST 16'h03E8
`define RSF_FREQ_RST 16'h01F4
`define RSF_PHASE_RST 32'h00FA_0000

`endif

// ---- rtl/rsf_pkg.sv ----
package rsf_pkg;

  // Channel sequencer states, one-hot.
  typedef enum logic [7:0] {
    CH_IDLE = 8'h01,
    CH_ON_WAIT = 8'h02,
    CH_SOFT = 8'h04,
    CH_REG = 8'h08,
    CH_OFF_WAIT = 8'h10,
    CH_RAMP_DN = 8'h20,
    CH_RETRY = 8'h40,
    CH_LATCH = 8'h80
  } rsf_cstate_t;

  // State of the top module, apart from its power-good filters and sync engine.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] cmd_on;
    logic [1:0][7:0] ccfg;
    logic [7:0] gcfg;
    logic [1:0] fcm;
    logic [31:0] on_t;
    logic [31:0] off_t;
    logic [15:0] retry_t;
    logic [15:0] period;
    logic [31:0] phase;
    logic [6:0] div;
    rsf_cstate_t [1:0] st;
    logic [1:0][15:0] cnt;
    logic [1:0] own_fault;
    logic [1:0][15:0] ph_cnt;
    logic [1:0] ph_arm;
    logic [1:0] pwm_set;
    logic [1:0][1:0] drop_cyc;
    logic [1:0][15:0] drop_cnt;
  } rsf_top_st_t;

endpackage : rsf_pkg

// ---- rtl/rsf_sync_if.sv ----
`timescale 1ns/1ps
// Timing reference between the sequencer and the sync engine.
interface rsf_sync_if;
  logic [15:0] period;
  logic master_en;
  logic ref_edge;
  logic ext_ok;
  logic drive_on;
  modport ctrl (output period, output master_en, input ref_edge, input ext_ok, input drive_on);
  modport eng (input period, input master_en, output ref_edge, output ext_ok, output drive_on);
endinterface : rsf_sync_if

// ---- rtl/rsf_pg_filter.sv ----
`timescale 1ns/1ps
`include "rsf_defs.svh"
module rsf_pg_filter #(
  parameter int TICKS = `RSF_PG_FILT_TICKS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Filter
  input wire logic tick,
  input wire logic raw,
  output logic filt
);
  typedef struct packed {
    logic out;
    logic [15:0] cnt;
  } rsf_pgf_st_t;
  rsf_pgf_st_t s_q, s_d;

  // Output follows only after the raw level has differed for the whole window.
  always_comb begin
    s_d = s_q;
    if (raw == s_q.out) begin
      s_d.cnt = 16'h0000;
    end else if (tick) begin
      if (s_q.cnt >= 16'(TICKS - 1)) begin
        s_d.out = raw;
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign filt = s_q.out;
endmodule : rsf_pg_filter

// ---- rtl/rsf_sync_eng.sv ----
`timescale 1ns/1ps
`include "rsf_defs.svh"
module rsf_sync_eng (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Open-drain sync pin
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  // Sequencer side
  rsf_sync_if.eng sif
);
  typedef struct packed {
    logic prev_in;
    logic [15:0] cnt;
    logic [6:0] pw;
    logic [16:0] ext_cnt;
    logic ext_ok;
    logic ref_edge;
  } rsf_sync_st_t;
  rsf_sync_st_t s_q, s_d;
  logic fall;
  logic foreign;
  logic int_edge;
  logic drive;

  // A falling edge while we are not pulling the line comes from another source.
  assign fall = s_q.prev_in & ~sync_in;
  assign foreign = fall & (s_q.pw == 7'h00);
  assign int_edge = (s_q.cnt >= sif.period - 16'h0001);
  assign drive = sif.master_en & ~s_q.ext_ok;

  // Oscillator, pulse generator and external clock qualification.
  always_comb begin
    s_d = s_q;
    s_d.prev_in = sync_in;
    s_d.ref_edge = 1'b0;
    s_d.cnt = int_edge ? 16'h0000 : s_q.cnt + 16'h0001;
    if (s_q.pw != 7'h00) begin
      s_d.pw = s_q.pw - 7'h01;
    end
    if (int_edge && drive) begin
      s_d.pw = 7'(`RSF_SYNC_PW_CYC);
    end
    if (s_q.ext_cnt != 17'h1FFFF) begin
      s_d.ext_cnt = s_q.ext_cnt + 17'h00001;
    end
    if (foreign) begin
      // Faster than the set fraction of the own rate: follow it and stop driving.
      s_d.ext_ok = (24'(s_q.ext_cnt) * 24'(`RSF_EXT_FREQ_PCT)) < (24'(sif.period) * 24'd100);
      s_d.ext_cnt = 17'h00000;
    end else if (s_q.ext_cnt > {sif.period, 1'b0}) begin
      s_d.ext_ok = 1'b0;
    end
    // Phase reference is the falling sync edge when following, else the own wrap.
    if (s_q.ext_ok) begin
      s_d.ref_edge = foreign;
      if (foreign) begin
        s_d.cnt = 16'h0000;
      end
    end else begin
      s_d.ref_edge = int_edge;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{prev_in: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = 1'b0;
  assign sync_oe = (s_q.pw != 7'h00);
  assign sif.ref_edge = s_q.ref_edge;
  assign sif.ext_ok = s_q.ext_ok;
  assign sif.drive_on = drive;
endmodule : rsf_sync_eng

// ---- rtl/rsf_ctrl.sv ----
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rsf_defs.svh"
module rsf_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Channel inputs
  input wire logic [1:0] channel_run_input,
  input wire logic [1:0] uv_ok,
  input wire logic [1:0] vout_decayed,
  input wire logic [1:0] fault_det,
  input wire logic [1:0] reverse_current_flag,
  input wire logic [1:0] high_avg_current,
  input wire logic [1:0] dropout_det,
  // Shared device inputs
  input wire logic vin_above_on,
  input wire logic vin_below_off,
  input wire logic share_clk_in,
  // Shared open-drain fault line
  input wire logic shared_fault_line_in,
  output logic shared_fault_line_out,
  output logic shared_fault_line_oe,
  // Open-drain sync line
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  // Channel outputs
  output logic [1:0] power_good_out,
  output logic [1:0] stage_en,
  output logic [1:0] cont_mode,
  output logic [1:0] bottom_gate_off,
  output logic [1:0] top_force_off,
  output logic [1:0] ramp_up,
  output logic [1:0] ramp_down,
  output logic [1:0] pwm_set
);
  rsf_pkg::rsf_top_st_t s_q, s_d;
  rsf_sync_if sif ();
  logic tick;
  logic both_off;
  logic ext_inhibit;
  logic [1:0] pg_raw;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------

  // True while the power stage of a channel is switching.
  function automatic logic fn_stage_on(input rsf_pkg::rsf_cstate_t st, input logic disc_off);
    fn_stage_on = (st == rsf_pkg::CH_SOFT) || (st == rsf_pkg::CH_REG) ||
                  (st == rsf_pkg::CH_OFF_WAIT) || ((st == rsf_pkg::CH_RAMP_DN) && !disc_off);
  endfunction : fn_stage_on

  // True while a channel is off for the purpose of the write interlock.
  function automatic logic fn_is_off(input rsf_pkg::rsf_cstate_t st);
    fn_is_off = (st == rsf_pkg::CH_IDLE) || (st == rsf_pkg::CH_RETRY) ||
                (st == rsf_pkg::CH_LATCH);
  endfunction : fn_is_off

  // ----------------------------------------
  // Time base and shared conditions
  // ----------------------------------------

  // Microsecond tick from the clock divider.
  assign tick = (s_q.div == 7'(`RSF_TICK_CYC - 1));
  assign both_off = fn_is_off(s_q.st[0]) && fn_is_off(s_q.st[1]);
  // Fault line pulled low by someone else, honoured only with inhibit response.
  assign ext_inhibit = s_q.gcfg[`RSF_GC_INHIBIT] & ~shared_fault_line_in &
                       ~(|s_q.own_fault);
  assign sif.period = s_q.period;
  assign sif.master_en = s_q.gcfg[`RSF_GC_MASTER];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Register file, channel sequencers, phase and dropout timing.
  always_comb begin
    logic on_ok;
    logic trip_o;
    logic disc_off;
    logic [7:0] cfg;
    logic [15:0] t_on;
    logic [15:0] t_rise;
    logic [15:0] t_off;
    logic [15:0] t_fall;
    logic [15:0] t_cnt;
    on_ok = 1'b0;
    trip_o = 1'b0;
    disc_off = 1'b0;
    cfg = 8'h00;
    t_on = s_q.on_t[15:0];
    t_rise = s_q.on_t[31:16];
    t_off = s_q.off_t[15:0];
    t_fall = s_q.off_t[31:16];
    t_cnt = 16'h0000;
    s_d = s_q;
    s_d.div = tick ? 7'h00 : s_q.div + 7'h01;

    // Bus slave: one wait cycle, then the answer with registered read data.
    s_d.ack = (read | write) & ~s_q.ack;
    if (read && !s_q.ack) begin
      unique case (address)
        `RSF_REG_CTRL: s_d.rdata = {30'h0, s_q.cmd_on};
        `RSF_REG_CCFG0: s_d.rdata = {24'h0, s_q.ccfg[0]};
        `RSF_REG_CCFG1: s_d.rdata = {24'h0, s_q.ccfg[1]};
        `RSF_REG_GCFG: s_d.rdata = {24'h0, s_q.gcfg};
        `RSF_REG_MODE: s_d.rdata = {30'h0, s_q.fcm};
        `RSF_REG_ON_T: s_d.rdata = s_q.on_t;
        `RSF_REG_OFF_T: s_d.rdata = s_q.off_t;
        `RSF_REG_RETRY: s_d.rdata = {16'h0, s_q.retry_t};
        `RSF_REG_FREQ: s_d.rdata = {16'h0, s_q.period};
        `RSF_REG_PHASE: s_d.rdata = s_q.phase;
        `RSF_REG_STATUS: begin
          s_d.rdata = {s_q.st[1], s_q.st[0], 5'h00, sif.drive_on, 4'h0, sif.ext_ok,
                       |s_q.own_fault, stage_en, power_good_out};
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (write && s_q.ack) begin
      unique case (address)
        `RSF_REG_CTRL: s_d.cmd_on = writedata[1:0];
        `RSF_REG_CCFG0: s_d.ccfg[0] = writedata[7:0];
        `RSF_REG_CCFG1: s_d.ccfg[1] = writedata[7:0];
        `RSF_REG_GCFG: s_d.gcfg = writedata[7:0];
        `RSF_REG_MODE: s_d.fcm = writedata[1:0];
        `RSF_REG_ON_T: s_d.on_t = writedata;
        `RSF_REG_OFF_T: s_d.off_t = writedata;
        `RSF_REG_RETRY: s_d.retry_t = writedata[15:0];
        `RSF_REG_FREQ: begin
          if (both_off && writedata[15:0] != 16'h0000) begin
            s_d.period = writedata[15:0];
          end
        end
        `RSF_REG_PHASE: begin
          if (both_off) begin
            s_d.phase = writedata;
          end
        end
        default: ;
      endcase
    end

    // Each channel runs its own sequencer; only the own_fault mask on ext_inhibit couples one to the other.
    for (int i = 0; i < 2; i++) begin
      cfg = s_q.ccfg[i];
      disc_off = cfg[`RSF_CC_DISC_OFF];
      t_cnt = s_q.cnt[i];
      trip_o = vin_below_off | ext_inhibit |
               (cfg[`RSF_CC_REQ_SHARE] & ~share_clk_in) |
               (s_q.gcfg[`RSF_GC_REQ_EXT] & ~sif.ext_ok);
      on_ok = s_q.cmd_on[i] & channel_run_input[i] & vin_above_on & ~trip_o;
      if (tick && t_cnt != 16'hFFFF) begin
        s_d.cnt[i] = t_cnt + 16'h0001;
      end
      unique case (s_q.st[i])
        rsf_pkg::CH_IDLE: begin
          s_d.cnt[i] = 16'h0000;
          s_d.own_fault[i] = 1'b0;
          if (on_ok) begin
            s_d.st[i] = rsf_pkg::CH_ON_WAIT;
          end
        end
        rsf_pkg::CH_ON_WAIT: begin
          if (!on_ok) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end else if (tick && t_cnt >= t_on) begin
            s_d.st[i] = rsf_pkg::CH_SOFT;
            s_d.cnt[i] = 16'h0000;
          end
        end
        rsf_pkg::CH_SOFT, rsf_pkg::CH_REG: begin
          if (trip_o) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end else if (!on_ok) begin
            s_d.st[i] = rsf_pkg::CH_OFF_WAIT;
            s_d.cnt[i] = 16'h0000;
          end else if (s_q.st[i] == rsf_pkg::CH_SOFT && tick && t_cnt >= t_rise) begin
            s_d.st[i] = rsf_pkg::CH_REG;
          end
        end
        rsf_pkg::CH_OFF_WAIT: begin
          if (trip_o) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end else if (tick && t_cnt >= t_off) begin
            s_d.st[i] = rsf_pkg::CH_RAMP_DN;
            s_d.cnt[i] = 16'h0000;
          end
        end
        rsf_pkg::CH_RAMP_DN: begin
          if (trip_o) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end else if (disc_off ? vout_decayed[i] : (tick && t_cnt >= t_fall)) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end
        end
        rsf_pkg::CH_RETRY: begin
          // Longer of the retry time and this output's own decay.
          if (t_cnt >= s_q.retry_t &&
              (cfg[`RSF_CC_SKIP_DECAY] || vout_decayed[i])) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end
        end
        rsf_pkg::CH_LATCH: begin
          if (!channel_run_input[i] || !s_q.cmd_on[i]) begin
            s_d.st[i] = rsf_pkg::CH_IDLE;
          end
        end
      endcase
      // A local fault overrides everything while the channel is starting or on.
      if (fault_det[i] && !fn_is_off(s_q.st[i])) begin
        s_d.st[i] = cfg[`RSF_CC_LATCH] ? rsf_pkg::CH_LATCH : rsf_pkg::CH_RETRY;
        s_d.cnt[i] = 16'h0000;
        s_d.own_fault[i] = 1'b1;
      end

      // Phase delay from the reference edge to the top-switch set pulse.
      s_d.pwm_set[i] = 1'b0;
      if (sif.ref_edge) begin
        s_d.ph_cnt[i] = 16'h0000;
        s_d.ph_arm[i] = 1'b1;
      end else if (s_q.ph_arm[i]) begin
        if (s_q.ph_cnt[i] >= s_q.phase[16*i +: 16]) begin
          s_d.pwm_set[i] = 1'b1;
          s_d.ph_arm[i] = 1'b0;
        end else begin
          s_d.ph_cnt[i] = s_q.ph_cnt[i] + 16'h0001;
        end
      end

      // Dropout refresh: every third cycle hold the top switch off briefly.
      if (s_q.drop_cnt[i] != 16'h0000) begin
        s_d.drop_cnt[i] = s_q.drop_cnt[i] - 16'h0001;
      end
      if (s_q.pwm_set[i]) begin
        if (!dropout_det[i]) begin
          s_d.drop_cyc[i] = 2'h0;
        end else if (s_q.drop_cyc[i] == 2'(`RSF_DROP_EVERY - 1)) begin
          s_d.drop_cyc[i] = 2'h0;
          s_d.drop_cnt[i] = 16'(s_q.period / 16'(`RSF_DROP_DIV)) +
                            16'(`RSF_DROP_EXTRA_CYC);
        end else begin
          s_d.drop_cyc[i] = s_q.drop_cyc[i] + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // All state of the block except the power-good filters and sync engine in one register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        cmd_on: `RSF_CTRL_RST,
        ccfg: {`RSF_CCFG_RST, `RSF_CCFG_RST},
        gcfg: `RSF_GCFG_RST,
        fcm: `RSF_MODE_RST,
        on_t: `RSF_ON_T_RST,
        off_t: `RSF_OFF_T_RST,
        retry_t: `RSF_RETRY_RST,
        period: `RSF_FREQ_RST,
        phase: `RSF_PHASE_RST,
        st: '{rsf_pkg::CH_IDLE, rsf_pkg::CH_IDLE},
        default: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Bus answer.
  assign waitrequest = (read | write) & ~s_q.ack;
  assign readdata = s_q.rdata;

  // The fault line is pulled while any channel sits in its own fault.
  assign shared_fault_line_out = 1'b0;
  assign shared_fault_line_oe = |s_q.own_fault;

  // Gate-drive controls decoded from the sequencer state, mode bits, channel inputs and dropout counter.
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      logic disc;
      assign disc = s_q.ccfg[g][`RSF_CC_DISC_OFF];
      assign stage_en[g] = fn_stage_on(s_q.st[g], disc);
      assign cont_mode[g] = stage_en[g] && (s_q.st[g] != rsf_pkg::CH_SOFT) &&
                            (s_q.fcm[g] || high_avg_current[g]);
      assign bottom_gate_off[g] = stage_en[g] & ~cont_mode[g] &
                                  reverse_current_flag[g];
      assign top_force_off[g] = (s_q.drop_cnt[g] != 16'h0000);
      assign ramp_up[g] = (s_q.st[g] == rsf_pkg::CH_SOFT);
      assign ramp_down[g] = (s_q.st[g] == rsf_pkg::CH_RAMP_DN) && !disc;
      assign pwm_set[g] = s_q.pwm_set[g] & stage_en[g];
      assign pg_raw[g] = uv_ok[g] & stage_en[g];
      rsf_pg_filter #(
        .TICKS(`RSF_PG_FILT_TICKS)
      ) u_pg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .raw(pg_raw[g]),
        .filt(power_good_out[g])
      );
    end
  endgenerate

  // Sync line master, follower and election.
  rsf_sync_eng u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sync_in(sync_in),
    .sync_out(sync_out),
    .sync_oe(sync_oe),
    .sif(sif)
  );
endmodule : rsf_ctrl

// ---- dv/rsf_ctrl_sva.sv ----
`timescale 1ns/1ps
module rsf_ctrl_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus and channel inputs
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [1:0] uv_ok,
  input wire logic [1:0] fault_det,
  input wire logic [1:0] reverse_current_flag,
  input wire logic [1:0] dropout_det,
  input wire logic vin_below_off,
  // Outputs under watch
  input wire logic sync_oe,
  input wire logic [1:0] power_good_out,
  input wire logic [1:0] stage_en,
  input wire logic [1:0] cont_mode,
  input wire logic [1:0] bottom_gate_off,
  input wire logic [1:0] top_force_off,
  input wire logic [1:0] ramp_up,
  input wire logic [1:0] pwm_set
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] held_q;
  // Counts the cycles for which the power-good condition of channel 0 has held.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 16'h0;
    end else begin
      held_q <= (uv_ok[0] && stage_en[0]) ? held_q + 16'h1 : 16'h0;
    end
  end
  // Each access gets exactly one wait cycle.
  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held too long");
  pg_filter_a: assert property ($rose(power_good_out[0]) |-> held_q >= 16'h3057)
    else $error("power good rose before filter time");
  stage_trip_a: assert property (vin_below_off |=> stage_en == 2'h0)
    else $error("stage still on after low input");
  fault_off_a: assert property (fault_det[0] |=> !stage_en[0])
    else $error("stage still on after fault");
  sync_pulse_a: assert property ($rose(sync_oe) |-> ##62 sync_oe ##1 !sync_oe)
    else $error("sync pulse width wrong");
  rev_gate_a: assert property (stage_en[0] && !cont_mode[0] && reverse_current_flag[0]
    |-> bottom_gate_off[0])
    else $error("bottom gate not cut on reverse current");
  soft_disc_a: assert property (ramp_up[0] |-> !cont_mode[0])
    else $error("soft start not discontinuous");
  pwm_gate_a: assert property (pwm_set[0] |-> stage_en[0])
    else $error("set edge while stage off");
  drop_load_a: assert property ($rose(top_force_off[0])
    |-> $past(pwm_set[0]) && $past(dropout_det[0]))
    else $error("refresh without dropout set edge");
endmodule : rsf_ctrl_sva
bind rsf_ctrl rsf_ctrl_sva rsf_ctrl_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .read(read),
  .write(write), .waitrequest(waitrequest), .uv_ok(uv_ok), .fault_det(fault_det),
  .reverse_current_flag(reverse_current_flag), .dropout_det(dropout_det),
  .vin_below_off(vin_below_off), .sync_oe(sync_oe), .power_good_out(power_good_out),
  .stage_en(stage_en), .cont_mode(cont_mode), .bottom_gate_off(bottom_gate_off),
  .top_force_off(top_force_off), .ramp_up(ramp_up), .pwm_set(pwm_set));

// ---- dv/rsf_peer_clk.sv ----
`timescale 1ns/1ps
module rsf_peer_clk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic en,
  input wire logic [15:0] period,
  // Open-drain sync pull
  output logic sync_pull
);
  logic [15:0] cnt_q;
  // Foreign master pulls low for half a period, inside the allowed duty band.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0;
      sync_pull <= 1'b0;
    end else begin
      cnt_q <= (cnt_q + 16'h1 >= period) ? 16'h0 : cnt_q + 16'h1;
      sync_pull <= en && (cnt_q < (period >> 1));
    end
  end
endmodule : rsf_peer_clk

// ---- dv/rsf_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module rsf_ctrl_tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, peer_en = 1'b0;
  logic vin_above_on = 1'b1, vin_below_off = 1'b0, share_clk_in = 1'b1;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [1:0] run = 2'h0, uv_ok = 2'h0, decayed = 2'h0, fault = 2'h0, rev = 2'h0;
  logic [1:0] hiavg = 2'h0, drop = 2'h0, pg, stage_en, cont_mode, bgo, tfo, rup, rdn, pwm_set;
  logic waitrequest, peer_pull, sync_out, sync_oe, fl_out, fl_oe;
  int num_errors = 0, checked = 0, n, m;
  // Free-running 125 MHz clock.
  always #4 ref_clk = ~ref_clk;
  rsf_peer_clk rsf_peer_clk_i (.ref_clk(ref_clk), .rst_n(rst_n), .en(peer_en),
    .period(16'h0190), .sync_pull(peer_pull));
  rsf_ctrl rsf_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .channel_run_input(run), .uv_ok(uv_ok), .vout_decayed(decayed), .fault_det(fault),
    .reverse_current_flag(rev), .high_avg_current(hiavg), .dropout_det(drop),
    .vin_above_on(vin_above_on), .vin_below_off(vin_below_off), .share_clk_in(share_clk_in),
    .shared_fault_line_in(!fl_oe), .shared_fault_line_out(fl_out),
    .shared_fault_line_oe(fl_oe), .sync_in(!(sync_oe || peer_pull)), .sync_out(sync_out),
    .sync_oe(sync_oe), .power_good_out(pg), .stage_en(stage_en), .cont_mode(cont_mode),
    .bottom_gate_off(bgo), .top_force_off(tfo), .ramp_up(rup), .ramp_down(rdn),
    .pwm_set(pwm_set));
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 50) num_errors++;
    @(posedge ref_clk);
  endtask : bus
  // Waits a bounded time for a channel stage enable to reach a level.
  task automatic wait_on(input int ch, input logic v, input int lim);
    n = 0;
    while (stage_en[ch] !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_on
  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h3);
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h1F4);
    bus(1'b0, 4'h9, 32'h0);
    chk(q, 32'h00FA_0000);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h5, 32'h0002_0001);
    bus(1'b1, 4'h6, 32'h0001_0001);
    bus(1'b1, 4'h7, 32'h0000_0001);
  endtask : t_regs
  task automatic t_start;
    uv_ok <= 2'h3;
    run <= 2'h3;
    repeat (200) @(posedge ref_clk);
    chk(stage_en, 2'h0);
    wait_on(0, 1'b1, 600);
    chk({rup[0], cont_mode[0]}, 2'h2);
    rev <= 2'h1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk(bgo[0], 1'b1);
    rev <= 2'h0;
    m = 0;
    while (pg[0] !== 1'b1 && m < 14000) begin
      @(posedge ref_clk);
      m++;
    end
    chk(m >= 12000, 1'b1);
    chk(pg, 2'h3);
    chk(cont_mode, 2'h3);
    drop <= 2'h1;
    // Third set edge under dropout loads one refresh of period/12 plus 13 cycles.
    m = 0;
    repeat (1600) begin
      @(posedge ref_clk);
      if (tfo[0] === 1'b1) m++;
    end
    chk(m, 54);
    drop <= 2'h0;
  endtask : t_start
  task automatic t_fault;
    fault <= 2'h1;
    @(posedge ref_clk);
    fault <= 2'h0;
    @(posedge ref_clk);
    chk(stage_en, 2'h2);
    chk({fl_out, fl_oe}, 2'h1);
    repeat (1000) @(posedge ref_clk);
    chk(stage_en[0], 1'b0);
    decayed <= 2'h1;
    wait_on(0, 1'b1, 1000);
    chk(stage_en[0], 1'b1);
    decayed <= 2'h0;
    bus(1'b1, 4'h1, 32'h08);
    fault <= 2'h1;
    @(posedge ref_clk);
    fault <= 2'h0;
    repeat (1000) @(posedge ref_clk);
    chk(stage_en[0], 1'b0);
    run <= 2'h2;
    repeat (3) @(posedge ref_clk);
    run <= 2'h3;
    wait_on(0, 1'b1, 1000);
    chk(stage_en[0], 1'b1);
    vin_below_off <= 1'b1;
    @(posedge ref_clk);
    vin_below_off <= 1'b0;
    @(posedge ref_clk);
    chk(stage_en, 2'h0);
  endtask : t_fault
  task automatic t_sync;
    n = 0;
    while (sync_oe !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({sync_oe, sync_out}, 2'h2);
    peer_en <= 1'b1;
    repeat (2000) @(posedge ref_clk);
    m = 0;
    repeat (1500) begin
      @(posedge ref_clk);
      if (sync_oe !== 1'b0) m++;
    end
    chk(m, 0);
    bus(1'b0, 4'hA, 32'h0);
    chk({q[10], q[5]}, 2'h1);
    peer_en <= 1'b0;
    n = 0;
    while (sync_oe !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(sync_oe, 1'b1);
  endtask : t_sync
  task automatic t_off;
    bus(1'b1, 4'h4, 32'h0);
    chk(cont_mode, 2'h0);
    hiavg <= 2'h3;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk(cont_mode, 2'h3);
    bus(1'b1, 4'h8, 32'h12C);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h1F4);
    run <= 2'h0;
    n = 0;
    while (rdn[0] !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    chk({rdn[0], stage_en[0], cont_mode[0]}, 3'h7);
    repeat (1500) @(posedge ref_clk);
    bus(1'b1, 4'h8, 32'h12C);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h12C);
  endtask : t_off
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence after a six-cycle reset.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_start;
    t_fault;
    t_sync;
    t_off;
    tally_and_finish;
  end
  // Watchdog cuts a hang short well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish;
  end
endmodule : rsf_ctrl_tb_top
